// ==== sim/touch_cdc_two_wire_register_port_tb.sv ====
// Self-checking bench for the two-wire register port
`timescale 1ns/100ps
`default_nettype none
module touch_cdc_two_wire_register_port_tb;
   logic        clk, reset, scl, sda_low, sda_line, sda_out, sda_oe;
   logic        status_event, status_clear, int_out, int_oe, core_we;
   logic        wr_valid;
   logic [9:0]  core_addr, wr_addr;
   logic [15:0] core_data, wr_data;
   logic [25:0] wq[$];
   int          failures, tests_run, clears;

   touch_cdc_two_wire_register_port touch_cdc_two_wire_register_port_inst (
      .CLK          (clk),
      .RESET        (reset),
      .SCL_IN       (scl),
      .SDA_IN       (sda_line),
      .SDA_OUT      (sda_out),
      .SDA_OE       (sda_oe),
      .STATUS_EVENT (status_event),
      .STATUS_CLEAR (status_clear),
      .INT_OUT      (int_out),
      .INT_OE       (int_oe),
      .CORE_WE      (core_we),
      .CORE_ADDR    (core_addr),
      .CORE_DATA    (core_data),
      .WR_VALID     (wr_valid),
      .WR_ADDR      (wr_addr),
      .WR_DATA      (wr_data)
   );

   two_wire_host_model two_wire_host_model_inst (
      .clk      (clk),
      .sda_line (sda_line),
      .scl      (scl),
      .sda_low  (sda_low)
   );

   // Open-drain wire with pull-up
   assign sda_line = !(sda_low || (sda_oe && !sda_out));

   always #50 clk = !clk;

   always @(negedge clk) begin
      if (wr_valid === 1'b1)
         wq.push_back({wr_addr, wr_data});
      if (status_clear === 1'b1)
         clears++;
   end

   //////////////////////////////////////////////////////////
   task automatic print_verdict();
      $display("tests_run=%0d failures=%0d", tests_run, failures);
      if (failures == 0 && tests_run > 0)
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   endtask

   task automatic check_val(input string what, input logic [25:0] exp,
                            input logic [25:0] got);
      tests_run++;
      if (got !== exp) begin
         failures++;
         $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
      end
   endtask

   task automatic expect_word(input logic [25:0] exp);
      int n;
      n = 0;
      while (wq.size() == 0 && n < 40) begin
         @(negedge clk);
         n++;
      end
      if (wq.size() == 0) begin
         failures++;
         print_verdict();
      end else begin
         check_val("word", exp, wq.pop_front());
      end
   endtask

   task automatic wr(input logic [7:0] b, input logic exp_n);
      logic [7:0] rx;
      logic       a;
      two_wire_host_model_inst.xfer(b, 1'b1, rx, a);
      check_val("ack", 26'(exp_n), 26'(a));
   endtask

   task automatic rd(input logic [7:0] exp, input logic nack);
      logic [7:0] rx;
      logic       a;
      two_wire_host_model_inst.xfer(8'hFF, nack, rx, a);
      check_val("read byte", 26'(exp), 26'(rx));
   endtask

   task automatic set_ptr(input logic [9:0] p);
      two_wire_host_model_inst.start();
      wr(8'h5C, 1'b0);
      wr({6'h3F, p[9:8]}, 1'b0);
      wr(p[7:0], 1'b0);
   endtask

   task automatic t_write();
      set_ptr(10'h005);
      wr(8'hAB, 1'b0);
      wr(8'hCD, 1'b0);
      expect_word({10'h005, 16'hABCD});
      wr(8'h12, 1'b0);
      wr(8'h34, 1'b0);
      expect_word({10'h006, 16'h1234});
      wr(8'h77, 1'b0);
      two_wire_host_model_inst.stop();
      repeat (20) @(negedge clk);
      check_val("odd byte", 26'h0, 26'(wq.size()));
   endtask

   task automatic t_read();
      set_ptr(10'h005);
      two_wire_host_model_inst.start();
      wr(8'h5D, 1'b0);
      rd(8'hAB, 1'b0);
      rd(8'hCD, 1'b0);
      rd(8'h12, 1'b0);
      rd(8'h34, 1'b1);
      two_wire_host_model_inst.stop();
   endtask

   task automatic t_wrong();
      logic [7:0] bad[2];
      bad = '{8'h5E, 8'h1C};
      foreach (bad[i]) begin
         two_wire_host_model_inst.start();
         wr(bad[i], 1'b1);
         wr(8'h00, 1'b1);
         two_wire_host_model_inst.stop();
      end
   endtask

   task automatic t_stop_ptr();
      core_we = 1'b1;
      core_addr = 10'h000;
      core_data = 16'h5A3C;
      @(negedge clk);
      core_we = 1'b0;
      set_ptr(10'h006);
      two_wire_host_model_inst.stop();
      two_wire_host_model_inst.start();
      wr(8'h5D, 1'b0);
      rd(8'h5A, 1'b0);
      rd(8'h3C, 1'b1);
      two_wire_host_model_inst.stop();
   endtask

   task automatic t_top();
      set_ptr(10'h3FF);
      wr(8'h11, 1'b0);
      wr(8'h22, 1'b0);
      wr(8'h33, 1'b0);
      wr(8'h44, 1'b0);
      expect_word({10'h3FF, 16'h1122});
      repeat (20) @(negedge clk);
      check_val("no wrap", 26'h0, 26'(wq.size()));
      two_wire_host_model_inst.start();
      wr(8'h5D, 1'b0);
      rd(8'h11, 1'b0);
      rd(8'h22, 1'b0);
      rd(8'h11, 1'b0);
      rd(8'h22, 1'b1);
      two_wire_host_model_inst.stop();
   endtask

   task automatic t_int();
      int c0;
      for (int s = 8; s <= 10; s++) begin
         core_we = 1'b1;
         core_addr = 10'(s);
         core_data = {8'hC3, 8'(s)};
         status_event = 1'b1;
         @(negedge clk);
         core_we = 1'b0;
         status_event = 1'b0;
         repeat (4) @(negedge clk);
         check_val("int set", 26'h1, 26'(int_oe));
         check_val("int level", 26'h0, 26'(int_out));
         c0 = clears;
         set_ptr(10'(s));
         two_wire_host_model_inst.start();
         wr(8'h5D, 1'b0);
         repeat (8) @(negedge clk);
         check_val("clear", 26'h1, 26'(clears - c0));
         check_val("int off", 26'h0, 26'(int_oe));
         rd(8'hC3, 1'b1);
         two_wire_host_model_inst.stop();
      end
   endtask

   task automatic t_stall();
      core_we = 1'b1;
      core_addr = 10'h100;
      set_ptr(10'h010);
      wr(8'h01, 1'b0);
      wr(8'h01, 1'b0);
      wr(8'h02, 1'b0);
      wr(8'h02, 1'b0);
      wr(8'h03, 1'b0);
      wr(8'h03, 1'b1);
      two_wire_host_model_inst.stop();
      core_we = 1'b0;
      expect_word({10'h010, 16'h0101});
      expect_word({10'h011, 16'h0202});
      repeat (10) @(negedge clk);
      check_val("drained", 26'h0, 26'(wq.size()));
   endtask

   initial begin
      clk = 1'b0;
      reset = 1'b1;
      status_event = 1'b0;
      core_we = 1'b0;
      core_addr = 10'h000;
      core_data = 16'h0000;
      failures = 0;
      tests_run = 0;
      repeat (8) @(negedge clk);
      reset = 1'b0;
      repeat (4) @(negedge clk);
      check_val("idle sda", 26'h0, 26'(sda_oe));
      check_val("sda level", 26'h0, 26'(sda_out));
      t_write();
      t_read();
      t_wrong();
      t_stop_ptr();
      t_top();
      t_int();
      t_stall();
      print_verdict();
   end
endmodule
`default_nettype wire

// ==== sim/two_wire_host_model.sv ====
// Bus master model driving the touch port's two-wire link
`timescale 1ns/100ps
`default_nettype none
module two_wire_host_model (
   input  wire logic clk,
   input  wire logic sda_line,
   output logic      scl,
   output logic      sda_low
);
   initial begin
      scl = 1'b1;
      sda_low = 1'b0;
   end

   //////////////////////////////////////////////////////////
   task automatic tick(input int n);
      repeat (n) @(negedge clk);
   endtask

   // Start or repeated start
   task automatic start();
      sda_low = 1'b0;
      tick(4);
      scl = 1'b1;
      tick(4);
      sda_low = 1'b1;
      tick(4);
      scl = 1'b0;
   endtask

   // Stop: SDA released while SCL high
   task automatic stop();
      tick(2);
      sda_low = 1'b1;
      tick(2);
      scl = 1'b1;
      tick(4);
      sda_low = 1'b0;
      tick(4);
   endtask

   // Data set while clock low, sampled mid high phase
   task automatic bit_cycle(input logic b, output logic seen);
      tick(2);
      sda_low = !b;
      tick(2);
      scl = 1'b1;
      tick(2);
      seen = sda_line;
      tick(2);
      scl = 1'b0;
   endtask

   // Eight data pulses then one acknowledge pulse
   task automatic xfer(input logic [7:0] tx, input logic ack_bit,
                       output logic [7:0] rx, output logic ack_n);
      for (int i = 7; i >= 0; i--)
         bit_cycle(tx[i], rx[i]);
      bit_cycle(ack_bit, ack_n);
   endtask
endmodule
`default_nettype wire

// ==== verilog/register_store.sv ====
// Register storage with one write port and a registered read port
`timescale 1ns/100ps
`default_nettype none
module register_store #(
   parameter int AW = 10,
   parameter int DW = 16
) (
   input  wire logic          CLK,
   input  wire logic          WE,
   input  wire logic [AW-1:0] WADDR,
   input  wire logic [DW-1:0] WDATA,
   input  wire logic [AW-1:0] RADDR,
   output logic      [DW-1:0] RDATA
);
   logic [DW-1:0] mem [0:(1<<AW)-1];

   always_ff @(posedge CLK) begin
      if (WE) begin
         mem[WADDR] <= WDATA;
      end
   end

   always_ff @(posedge CLK) begin
      RDATA <= mem[RADDR];
   end
endmodule
`default_nettype wire

// ==== verilog/touch_cdc_two_wire_register_port.sv ====
// Two-wire slave port to the 16-bit register map of the touch controller
`timescale 1ns/100ps
`default_nettype none
module touch_cdc_two_wire_register_port (
   input  wire logic        CLK,
   input  wire logic        RESET,
   input  wire logic        SCL_IN,
   input  wire logic        SDA_IN,
   output logic             SDA_OUT,
   output logic             SDA_OE,
   input  wire logic        STATUS_EVENT,
   output logic             STATUS_CLEAR,
   output logic             INT_OUT,
   output logic             INT_OE,
   input  wire logic        CORE_WE,
   input  wire logic [9:0]  CORE_ADDR,
   input  wire logic [15:0] CORE_DATA,
   output logic             WR_VALID,
   output logic [9:0]       WR_ADDR,
   output logic [15:0]      WR_DATA
);
   ////////////////////////////////////////////////////////////////////////
   // Declarations
   touch_port_pkg::port_state_type state_reg;
   logic [2:0]  scl_sync_reg;
   logic [2:0]  sda_sync_reg;
   logic        scl_rise;
   logic        scl_fall;
   logic        start_det;
   logic        stop_det;
   logic [3:0]  bit_cnt_reg;
   logic [7:0]  shift_reg;
   logic [7:0]  tx_reg;
   logic        rw_reg;
   logic        nack_reg;
   logic        rd_lo_reg;
   logic [1:0]  byte_idx_reg;
   logic [1:0]  ptr_hi_reg;
   logic [7:0]  data_hi_reg;
   logic [9:0]  ptr_reg;
   logic        at_end_reg;
   logic        sda_oe_reg;
   logic        int_pend_reg;
   logic        addr_match;
   logic        byte_done;
   logic        word_done;
   logic        push;
   logic        pop;
   logic        buf_ready;
   logic [1:0]  buf_cnt_reg;
   logic        buf_wp_reg;
   logic        buf_rp_reg;
   logic [9:0]  buf_addr_reg [0:1];
   logic [15:0] buf_data_reg [0:1];
   logic        mem_we;
   logic [9:0]  mem_waddr;
   logic [15:0] mem_wdata;
   logic [15:0] rd_data;
   logic        stat_read;
   ////////////////////////////////////////////////////////////////////////
   // Line synchronisers and condition detection
   always_ff @(posedge CLK or posedge RESET) begin
      if (RESET) begin
         scl_sync_reg <= 3'h7;
         sda_sync_reg <= 3'h7;
      end else begin
         scl_sync_reg <= {scl_sync_reg[1:0], SCL_IN}; // R23
         sda_sync_reg <= {sda_sync_reg[1:0], SDA_IN}; // R23
      end
   end
   assign scl_rise  = scl_sync_reg[1] & ~scl_sync_reg[2];
   assign scl_fall  = ~scl_sync_reg[1] & scl_sync_reg[2];
   assign start_det = scl_sync_reg[1] & scl_sync_reg[2] &
                      ~sda_sync_reg[1] & sda_sync_reg[2]; // R3
   assign stop_det  = scl_sync_reg[1] & scl_sync_reg[2] &
                      sda_sync_reg[1] & ~sda_sync_reg[2]; // R9
   assign addr_match = shift_reg[7:1] == touch_port_pkg::DEV_ADDR; // R2
   assign byte_done  = bit_cnt_reg == touch_port_pkg::BIT_LAST;
   assign word_done  = scl_fall && state_reg == touch_port_pkg::ST_WR_BYTE
                       && byte_done
                       && byte_idx_reg == touch_port_pkg::IDX_DATA_LO;
   assign push       = word_done && !at_end_reg && buf_ready; // R15 R22
   assign stat_read  = ptr_reg == touch_port_pkg::STAT_LOW_ADDR ||
                       ptr_reg == touch_port_pkg::STAT_HIGH_ADDR ||
                       ptr_reg == touch_port_pkg::STAT_DONE_ADDR;
   ////////////////////////////////////////////////////////////////////////
   // Protocol state machine
   always_ff @(posedge CLK or posedge RESET) begin
      if (RESET) begin
         state_reg    <= touch_port_pkg::ST_IDLE;
         bit_cnt_reg  <= 4'h0;
         shift_reg    <= 8'h00;
         tx_reg       <= 8'h00;
         rw_reg       <= 1'b0;
         nack_reg     <= 1'b0;
         rd_lo_reg    <= 1'b0;
         byte_idx_reg <= 2'h0;
         ptr_hi_reg   <= 2'h0;
         data_hi_reg  <= 8'h00;
         sda_oe_reg   <= 1'b0;
      end else if (stop_det) begin
         state_reg  <= touch_port_pkg::ST_IDLE; // R9
         sda_oe_reg <= 1'b0;
      end else if (start_det) begin
         state_reg    <= touch_port_pkg::ST_ADDR; // R3
         bit_cnt_reg  <= 4'h0;
         byte_idx_reg <= touch_port_pkg::IDX_PTR_HI;
         sda_oe_reg   <= 1'b0;
      end else if (scl_rise) begin
         unique case (state_reg)
            touch_port_pkg::ST_ADDR,
            touch_port_pkg::ST_WR_BYTE: begin
               shift_reg   <= {shift_reg[6:0], sda_sync_reg[1]}; // R4
               bit_cnt_reg <= bit_cnt_reg + 4'h1;
            end
            touch_port_pkg::ST_RD_BYTE: begin
               bit_cnt_reg <= bit_cnt_reg + 4'h1;
            end
            touch_port_pkg::ST_ACK_RD: begin
               nack_reg <= sda_sync_reg[1];
            end
            touch_port_pkg::ST_IDLE, touch_port_pkg::ST_ACK_ADR,
            touch_port_pkg::ST_ACK_WR: ;
            default: state_reg <= touch_port_pkg::ST_IDLE;
         endcase
      end else if (scl_fall) begin
         unique case (state_reg)
            touch_port_pkg::ST_ADDR: begin
               if (byte_done) begin
                  if (addr_match) begin
                     state_reg  <= touch_port_pkg::ST_ACK_ADR;
                     rw_reg     <= shift_reg[0]; // R6
                     sda_oe_reg <= 1'b1; // R5
                  end else begin
                     state_reg <= touch_port_pkg::ST_IDLE; // R5
                  end
               end
            end
            touch_port_pkg::ST_ACK_ADR: begin
               bit_cnt_reg <= 4'h0;
               if (rw_reg) begin
                  state_reg  <= touch_port_pkg::ST_RD_BYTE; // R6
                  tx_reg     <= rd_data[15:8]; // R17
                  rd_lo_reg  <= 1'b0;
                  sda_oe_reg <= ~rd_data[15];
               end else begin
                  state_reg  <= touch_port_pkg::ST_WR_BYTE;
                  sda_oe_reg <= 1'b0;
               end
            end
            touch_port_pkg::ST_WR_BYTE: begin
               if (byte_done) begin
                  state_reg  <= touch_port_pkg::ST_ACK_WR; // R7
                  sda_oe_reg <= !word_done || at_end_reg || buf_ready;
                  byte_idx_reg <= (byte_idx_reg ==
                                   touch_port_pkg::IDX_DATA_LO) ?
                                  touch_port_pkg::IDX_DATA_HI :
                                  byte_idx_reg + 2'h1; // R13
                  if (byte_idx_reg == touch_port_pkg::IDX_PTR_HI) begin
                     ptr_hi_reg <= shift_reg[1:0]; // R10 R11
                  end
                  if (byte_idx_reg == touch_port_pkg::IDX_DATA_HI) begin
                     data_hi_reg <= shift_reg; // R12
                  end
               end
            end
            touch_port_pkg::ST_ACK_WR: begin
               state_reg   <= touch_port_pkg::ST_WR_BYTE;
               bit_cnt_reg <= 4'h0;
               sda_oe_reg  <= 1'b0;
            end
            touch_port_pkg::ST_RD_BYTE: begin
               if (byte_done) begin
                  state_reg  <= touch_port_pkg::ST_ACK_RD;
                  sda_oe_reg <= 1'b0;
               end else begin
                  tx_reg     <= {tx_reg[6:0], 1'b0};
                  sda_oe_reg <= ~tx_reg[6]; // R8
               end
            end
            touch_port_pkg::ST_ACK_RD: begin
               bit_cnt_reg <= 4'h0;
               if (nack_reg) begin
                  state_reg <= touch_port_pkg::ST_IDLE; // R18
               end else begin
                  state_reg  <= touch_port_pkg::ST_RD_BYTE;
                  rd_lo_reg  <= ~rd_lo_reg;
                  tx_reg     <= rd_lo_reg ? rd_data[15:8] : rd_data[7:0];
                  sda_oe_reg <= rd_lo_reg ? ~rd_data[15] : ~rd_data[7];
               end
            end
            touch_port_pkg::ST_IDLE: ;
            default: state_reg <= touch_port_pkg::ST_IDLE;
         endcase
      end
   end
   ////////////////////////////////////////////////////////////////////////
   // Register pointer
   always_ff @(posedge CLK or posedge RESET) begin
      if (RESET) begin
         ptr_reg    <= touch_port_pkg::PTR_RESET;
         at_end_reg <= 1'b0;
      end else if (stop_det) begin
         ptr_reg    <= touch_port_pkg::PTR_RESET; // R9
         at_end_reg <= 1'b0;
      end else if (scl_fall && state_reg == touch_port_pkg::ST_WR_BYTE &&
                   byte_done &&
                   byte_idx_reg == touch_port_pkg::IDX_PTR_LO) begin
         ptr_reg    <= {ptr_hi_reg, shift_reg}; // R10
         at_end_reg <= 1'b0;
      end else if (push || (scl_fall && rd_lo_reg && byte_done &&
                   state_reg == touch_port_pkg::ST_RD_BYTE)) begin
         if (ptr_reg == touch_port_pkg::PTR_MAX) begin
            at_end_reg <= 1'b1; // R14 R19
         end else begin
            ptr_reg <= ptr_reg + 10'h001; // R14 R18
         end
      end
   end
   ////////////////////////////////////////////////////////////////////////
   // Interrupt status
   always_ff @(posedge CLK or posedge RESET) begin
      if (RESET) begin
         int_pend_reg <= 1'b0;
         STATUS_CLEAR <= 1'b0;
      end else begin
         STATUS_CLEAR <= scl_fall && state_reg == touch_port_pkg::ST_ADDR &&
                         byte_done && addr_match && shift_reg[0] &&
                         stat_read; // R21
         if (STATUS_EVENT) begin
            int_pend_reg <= 1'b1;
         end else if (STATUS_CLEAR) begin
            int_pend_reg <= 1'b0; // R21
         end
      end
   end
   ////////////////////////////////////////////////////////////////////////
   // Two-entry write buffer
   assign buf_ready = buf_cnt_reg != touch_port_pkg::BUF_DEPTH;
   assign pop       = buf_cnt_reg != 2'h0 && !CORE_WE;
   always_ff @(posedge CLK or posedge RESET) begin
      if (RESET) begin
         buf_cnt_reg     <= 2'h0;
         buf_wp_reg      <= 1'b0;
         buf_rp_reg      <= 1'b0;
         buf_addr_reg[0] <= 10'h000;
         buf_addr_reg[1] <= 10'h000;
         buf_data_reg[0] <= 16'h0000;
         buf_data_reg[1] <= 16'h0000;
      end else begin
         if (push) begin
            buf_addr_reg[buf_wp_reg] <= ptr_reg;
            buf_data_reg[buf_wp_reg] <= {data_hi_reg, shift_reg}; // R22
            buf_wp_reg <= ~buf_wp_reg;
         end
         if (pop) begin
            buf_rp_reg <= ~buf_rp_reg;
         end
         buf_cnt_reg <= buf_cnt_reg + {1'b0, push} - {1'b0, pop};
      end
   end
   assign mem_we    = CORE_WE | pop;
   assign mem_waddr = CORE_WE ? CORE_ADDR : buf_addr_reg[buf_rp_reg];
   assign mem_wdata = CORE_WE ? CORE_DATA : buf_data_reg[buf_rp_reg];
   register_store #(
      .AW (touch_port_pkg::ADDR_W),
      .DW (touch_port_pkg::DATA_W)
   ) store (
      .CLK   (CLK),
      .WE    (mem_we),
      .WADDR (mem_waddr),
      .WDATA (mem_wdata),
      .RADDR (ptr_reg),
      .RDATA (rd_data)
   );
   ////////////////////////////////////////////////////////////////////////
   // Registered outputs
   always_ff @(posedge CLK or posedge RESET) begin
      if (RESET) begin
         SDA_OUT  <= 1'b0;
         SDA_OE   <= 1'b0;
         INT_OUT  <= 1'b0;
         INT_OE   <= 1'b0;
         WR_VALID <= 1'b0;
         WR_ADDR  <= 10'h000;
         WR_DATA  <= 16'h0000;
      end else begin
         SDA_OUT  <= 1'b0;
         SDA_OE   <= sda_oe_reg; // R1
         INT_OUT  <= 1'b0;
         INT_OE   <= int_pend_reg;
         WR_VALID <= pop;
         WR_ADDR  <= buf_addr_reg[buf_rp_reg];
         WR_DATA  <= buf_data_reg[buf_rp_reg];
      end
   end
   ////////////////////////////////////////////////////////////////////////
   // Assertions
   property p_idle_quiet;
      @(posedge CLK) disable iff (RESET)
      state_reg == touch_port_pkg::ST_IDLE |-> !sda_oe_reg;
   endproperty
   a_idle_quiet: assert property (p_idle_quiet) // R1
      else $error("SDA driven while idle");
   property p_ack_match;
      @(posedge CLK) disable iff (RESET)
      scl_fall && state_reg == touch_port_pkg::ST_ADDR && byte_done &&
      !addr_match |=> state_reg == touch_port_pkg::ST_IDLE && !sda_oe_reg;
   endproperty
   a_ack_match: assert property (p_ack_match) // R2
      else $error("Foreign address not ignored");
   property p_start;
      @(posedge CLK) disable iff (RESET)
      start_det && !stop_det |=>
         state_reg == touch_port_pkg::ST_ADDR && bit_cnt_reg == 4'h0;
   endproperty
   a_start: assert property (p_start) // R3
      else $error("Start not taken");
   property p_bit_count;
      @(posedge CLK) disable iff (RESET)
      bit_cnt_reg <= 4'h8;
   endproperty
   a_bit_count: assert property (p_bit_count) // R4
      else $error("Bit count past eight");
   property p_ack_drive;
      @(posedge CLK) disable iff (RESET)
      $rose(sda_oe_reg) && state_reg == touch_port_pkg::ST_ACK_ADR |->
         $past(addr_match) && $past(bit_cnt_reg) == 4'h8;
   endproperty
   a_ack_drive: assert property (p_ack_drive) // R5
      else $error("Acknowledge without match");
   property p_scl_low;
      @(posedge CLK) disable iff (RESET)
      $changed(sda_oe_reg) && !$past(stop_det) && !$past(start_det)
         |-> !scl_sync_reg[2];
   endproperty
   a_scl_low: assert property (p_scl_low) // R8
      else $error("SDA moved while SCL high");
   property p_stop;
      @(posedge CLK) disable iff (RESET)
      stop_det |=> state_reg == touch_port_pkg::ST_IDLE &&
         ptr_reg == touch_port_pkg::PTR_RESET && !at_end_reg;
   endproperty
   a_stop: assert property (p_stop) // R9
      else $error("Stop did not reset port");
   property p_advance;
      @(posedge CLK) disable iff (RESET)
      push && ptr_reg != touch_port_pkg::PTR_MAX && !stop_det |=>
         ptr_reg == $past(ptr_reg) + 10'h001;
   endproperty
   a_advance: assert property (p_advance) // R14
      else $error("Pointer did not advance");
   property p_discard;
      @(posedge CLK) disable iff (RESET)
      at_end_reg |-> !push && ptr_reg == touch_port_pkg::PTR_MAX;
   endproperty
   a_discard: assert property (p_discard) // R15 R19
      else $error("Write past end not discarded");
   property p_status;
      @(posedge CLK) disable iff (RESET)
      STATUS_CLEAR && !STATUS_EVENT |=> ##1 !INT_OE;
   endproperty
   a_status: assert property (p_status) // R21
      else $error("Interrupt not released");
endmodule
`default_nettype wire

// ==== verilog/touch_port_pkg.sv ====
// Constants for the touch controller two-wire register port
//
// Summary of operation
// R1 - Port is a bus slave only; it never starts a transfer itself.
// R2 - Answers only to the fixed 7-bit address 0101 110.
// R3 - Start is SDA falling while SCL high; detected at any time.
// R4 - After start, eight bits shift in MSB first: address then direction.
// R5 - Matching address is acknowledged by driving SDA low on ninth pulse.
// R6 - Direction 0 is a master write, direction 1 is a master read.
// R7 - Each byte is eight data pulses plus one acknowledge pulse.
// R8 - SDA changes only while SCL is low, except start and stop.
// R9 - Stop is SDA rising while SCL high; go idle, pointer to zero.
// R10 - Two bytes after address form the 10-bit register pointer.
// R11 - Bits 7 to 2 of the first pointer byte are ignored.
// R12 - Next byte is the upper data half, following byte the lower.
// R13 - Registers are 16 bits; writes come as byte pairs.
// R14 - Pointer advances after each written word and never wraps.
// R15 - Write data after the pointer reached its maximum is discarded.
// R16 - Master loads the pointer by a write before any read.
// R17 - Read returns upper byte first, then lower byte.
// R18 - Pointer advances after each read word; reads run until master NACK.
// R19 - At maximum pointer, reads repeat the last register.
// R20 - Master ends a write with stop or repeated start.
// R21 - Read set up at a status register clears status and releases INT.
// R22 - A word commits only after both bytes; odd trailing byte dropped.
// R23 - SCL and SDA pass synchronisers; start and stop from synced edges.
package touch_port_pkg;
   localparam int          ADDR_W        = 10;
   localparam int          DATA_W        = 16;
   localparam logic [6:0]  DEV_ADDR      = 7'h2E;
   localparam logic [9:0]  PTR_RESET     = 10'h000;
   localparam logic [9:0]  PTR_MAX       = 10'h3FF;
   localparam logic [9:0]  STAT_LOW_ADDR = 10'h008;
   localparam logic [9:0]  STAT_HIGH_ADDR = 10'h009;
   localparam logic [9:0]  STAT_DONE_ADDR = 10'h00A;
   localparam logic [3:0]  BIT_LAST      = 4'h8;
   localparam logic [1:0]  IDX_PTR_HI    = 2'h0;
   localparam logic [1:0]  IDX_PTR_LO    = 2'h1;
   localparam logic [1:0]  IDX_DATA_HI   = 2'h2;
   localparam logic [1:0]  IDX_DATA_LO   = 2'h3;
   localparam logic [1:0]  BUF_DEPTH     = 2'h2;

   typedef enum logic [2:0] {
      ST_IDLE    = 3'b000,
      ST_ADDR    = 3'b001,
      ST_ACK_ADR = 3'b010,
      ST_WR_BYTE = 3'b011,
      ST_ACK_WR  = 3'b100,
      ST_RD_BYTE = 3'b101,
      ST_ACK_RD  = 3'b110
   } port_state_type;
endpackage
